// ===== core/pic_core.sv
/*
 * Prioritized interrupt controller core: collects pin, internal and
 * exception requests, ranks them and offers one vector to the core.
 * Assumes one 10 MHz clock, synchronous reset and a plain register port
 * driven on the same clock; pins arrive asynchronously.
 */
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_core #(
   parameter int NSRC = `PIC_NSRC
) (
   // Clock and reset
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   // Register port
   input  wire pic_pkg::pic_bus_type bus_in,
   output logic [31:0]               bus_rdata_out,
   // Pins
   input  wire logic                 ext_request_pin_0_in,
   input  wire logic                 ext_request_pin_1_in,
   input  wire logic                 ext_request_pin_2_in,
   input  wire logic                 ext_request_pin_3_in,
   input  wire logic                 ext_request_pin_4_in,
   input  wire logic                 nmi_pin_in,
   input  wire logic [7:0]           ext_vector_pin_in,
   // Internal sources
   input  wire logic [2:0]           timer_req_in,
   input  wire logic [1:0]           dma_req_in,
   input  wire logic                 watchdog_req_in,
   input  wire logic                 serial_req_in,
   // Processor core
   input  wire logic [5:0]           exc_req_in,
   input  wire logic                 trace_req_in,
   input  wire logic                 core_ack_in,
   input  wire logic                 core_set_if_in,
   input  wire logic                 core_clr_if_in,
   output logic                      core_req_out,
   output logic [7:0]                core_type_out,
   output logic [9:0]                core_vec_addr_out,
   output logic [9:0]                in_service_flags_out,
   output logic                      irq_out
);

   generate
      if (NSRC != `PIC_NSRC) begin : g_bad_nsrc
         $error("pic_core serves exactly ten source slots");
      end
   endgenerate

   pic_pkg::pic_state_type s_reg;
   pic_pkg::pic_state_type s_next;

   // ------------------------------------------------------------
   // Source helpers
   // ------------------------------------------------------------
   // Slots: 0 timers, 1-2 DMA, 3-7 pins 0-4, 8 watchdog, 9 serial

   function automatic logic [7:0] master_type(input logic [3:0] i,
                                               input logic [2:0] tp);
      logic [7:0] t;
      t = `PIC_TYPE_SER;
      unique case (i)
         4'h0: begin
            if (tp[0]) begin
               t = `PIC_TYPE_TMR0;
            end else if (tp[1]) begin
               t = `PIC_TYPE_TMR1;
            end else begin
               t = `PIC_TYPE_TMR2;
            end
         end
         4'h1: t = `PIC_TYPE_DMA0;
         4'h2: t = `PIC_TYPE_DMA1;
         4'h3, 4'h4, 4'h5, 4'h6: t = `PIC_TYPE_PIN0 + {5'h00, i[2:0] - 3'h3};
         4'h7: t = `PIC_TYPE_PIN4;
         4'h8: t = `PIC_TYPE_WDOG;
         default: t = `PIC_TYPE_SER;
      endcase
      return t;
   endfunction

   // End-of-interrupt type per slot; timers share one
   function automatic logic [7:0] eoi_type(input logic [3:0] i);
      return (i == 4'h0) ? `PIC_TYPE_TMR0 : master_type(i, 3'h0);
   endfunction

   // ------------------------------------------------------------
   // Ranking
   // ------------------------------------------------------------
   logic [NSRC-1:0] avail;
   logic [NSRC-1:0] elig;
   logic [NSRC-1:0] pin_rise;
   logic [3:0]      cur_lvl;
   logic            found;
   logic [3:0]      best;
   logic [2:0]      best_lvl;
   logic [7:0]      sel_type;

   // Slave mode keeps only timers, DMA and the master request on pin 0
   assign avail = s_reg.slave ? 10'h00F : 10'h3FF;

   always_comb begin
      cur_lvl = `PIC_LVL_NONE;
      for (int i = 0; i < NSRC; i++) begin
         if (s_reg.isr[i] && {1'b0, s_reg.prio[3*i +: 3]} < cur_lvl) begin
            cur_lvl = {1'b0, s_reg.prio[3*i +: 3]};
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         logic unblocked;
         // Pins 0 and 1 may ignore their own in-service bit
         if (g == 3 || g == 4) begin : g_sfn
            assign unblocked = ~s_reg.isr[g] | s_reg.sfn[g-3];
         end else begin : g_plain
            assign unblocked = ~s_reg.isr[g];
         end
         // Equal level is allowed once the enable is back
         assign elig[g] = s_reg.pend[g] & ~s_reg.mask[g] & avail[g] & unblocked &
                          ({1'b0, s_reg.prio[3*g +: 3]} <= cur_lvl);
      end
   endgenerate

   always_comb begin
      found    = 1'b0;
      best     = 4'h0;
      best_lvl = 3'h7;
      for (int i = 0; i < NSRC; i++) begin
         if (elig[i] && (!found || s_reg.prio[3*i +: 3] < best_lvl)) begin
            found    = 1'b1;
            best     = 4'(i);
            best_lvl = s_reg.prio[3*i +: 3];
         end
      end
   end

   always_comb begin
      sel_type = master_type(best, s_reg.tmr_pend);
      if (s_reg.slave) begin
         if (best == 4'h0) begin
            if (s_reg.tmr_pend[0]) begin
               sel_type = {s_reg.base, 3'h0};
            end else if (s_reg.tmr_pend[1]) begin
               sel_type = {s_reg.base, 3'h1};
            end else begin
               sel_type = {s_reg.base, 3'h2};
            end
         end else if (best == 4'h1 || best == 4'h2) begin
            sel_type = {s_reg.base, best[2:0] + 3'h2};
         end else begin
            sel_type = s_reg.evec2;
         end
      end
   end

   // Rising edges of synced pins, slot order 3..7
   assign pin_rise = {2'b00, s_reg.sync2[4:0] & ~s_reg.prev[4:0], 3'h0};

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic [NSRC-1:0]      ev_src;
   logic [NSRC-1:0]      eoi_clr;
   logic [`PIC_NEVT-1:0] ev_set;
   logic                 acked;
   logic                 eoi_hit;
   logic                 exc_any;
   logic [2:0]           exc_idx;

   always_comb begin
      s_next  = s_reg;
      ev_set  = '0;
      eoi_clr = '0;
      eoi_hit = 1'b0;
      acked   = core_ack_in & s_reg.req;

      // Pin synchronisers; pins then NMI
      s_next.sync1 = {nmi_pin_in, ext_request_pin_4_in, ext_request_pin_3_in,
                      ext_request_pin_2_in, ext_request_pin_1_in, ext_request_pin_0_in};
      s_next.sync2 = s_reg.sync1;
      s_next.prev  = s_reg.sync2;
      s_next.evec1 = ext_vector_pin_in;
      s_next.evec2 = s_reg.evec1;

      ev_src = pin_rise | {serial_req_in, watchdog_req_in, 5'h00, dma_req_in, |timer_req_in};

      // Clear on acceptance first so a new edge in the same cycle wins
      if (acked) begin
         unique case (s_reg.kind)
            pic_pkg::PIC_KIND_EXC:   s_next.exc_pend[s_reg.idx[2:0]] = 1'b0;
            pic_pkg::PIC_KIND_TRACE: s_next.trace_pend = 1'b0;
            pic_pkg::PIC_KIND_NMI:   s_next.nmi_pend = 1'b0;
            pic_pkg::PIC_KIND_MASK: begin
               s_next.pend[s_reg.idx] = 1'b0;
               s_next.isr[s_reg.idx]  = 1'b1;
               ev_set[0]              = 1'b1;
               if (s_reg.idx == 4'h0) begin
                  if (s_reg.tmr_pend[0]) begin
                     s_next.tmr_pend[0] = 1'b0;
                  end else if (s_reg.tmr_pend[1]) begin
                     s_next.tmr_pend[1] = 1'b0;
                  end else begin
                     s_next.tmr_pend[2] = 1'b0;
                  end
                  s_next.pend[0] = (s_next.tmr_pend != 3'h0);
               end
            end
         endcase
         s_next.if_en = 1'b0;
         if (s_reg.kind == pic_pkg::PIC_KIND_EXC) begin
            ev_set[2] = 1'b1;
         end
      end

      s_next.pend     = s_next.pend | ev_src;
      s_next.tmr_pend = s_next.tmr_pend | timer_req_in;
      s_next.exc_pend = s_next.exc_pend | exc_req_in;
      if (trace_req_in) begin
         s_next.trace_pend = 1'b1;
      end
      if (s_reg.sync2[5] && !s_reg.prev[5]) begin
         s_next.nmi_pend = 1'b1;
         ev_set[1]       = 1'b1;
      end

      if (core_set_if_in) begin
         s_next.if_en = 1'b1;
      end else if (core_clr_if_in) begin
         s_next.if_en = 1'b0;
      end

      // Register writes
      if (bus_in.wr) begin
         unique case (bus_in.addr)
            `PIC_ADDR_CTRL: begin
               s_next.slave = bus_in.wdata[`PIC_CTRL_SLAVE];
               s_next.sfn   = {bus_in.wdata[`PIC_CTRL_SFN1], bus_in.wdata[`PIC_CTRL_SFN0]};
            end
            `PIC_ADDR_MASK:  s_next.mask  = bus_in.wdata[NSRC-1:0];
            `PIC_ADDR_PRIO:  s_next.prio  = bus_in.wdata[3*NSRC-1:0];
            `PIC_ADDR_BASE:  s_next.base  = bus_in.wdata[4:0];
            `PIC_ADDR_EVMSK: s_next.evmsk = bus_in.wdata[`PIC_NEVT-1:0];
            `PIC_ADDR_EOI: begin
               for (int i = 0; i < NSRC; i++) begin
                  if (eoi_type(4'(i)) == bus_in.wdata[7:0]) begin
                     eoi_clr[i] = 1'b1;
                     eoi_hit    = 1'b1;
                  end
               end
               ev_set[3] = ~eoi_hit;
            end
            default: begin
            end
         endcase
      end
      // Freshly accepted slot is kept even if an EOI lands in that cycle
      s_next.isr = s_next.isr & ~(eoi_clr & ~(s_next.isr & ~s_reg.isr));

      // Event status: write one to clear, a new event wins
      s_next.evst = s_reg.evst;
      if (bus_in.wr && bus_in.addr == `PIC_ADDR_EVST) begin
         s_next.evst = s_reg.evst & ~bus_in.wdata[`PIC_NEVT-1:0];
      end
      s_next.evst = s_next.evst | ev_set;

      // Presentation: exceptions, trace, NMI, then maskable ranking
      exc_any = |s_reg.exc_pend;
      exc_idx = 3'h0;
      for (int i = `PIC_NEXC - 1; i >= 0; i--) begin
         if (s_reg.exc_pend[i]) begin
            exc_idx = 3'(i);
         end
      end
      s_next.req = 1'b0;
      if (!acked) begin
         if (exc_any) begin
            s_next.req  = 1'b1;
            s_next.kind = pic_pkg::PIC_KIND_EXC;
            s_next.idx  = {1'b0, exc_idx};
            s_next.typ  = 8'(`PIC_EXC_TYPES >> ({5'h00, exc_idx} * 8'h08));
         end else if (s_reg.trace_pend) begin
            s_next.req  = 1'b1;
            s_next.kind = pic_pkg::PIC_KIND_TRACE;
            s_next.idx  = 4'h0;
            s_next.typ  = `PIC_TYPE_TRACE;
         end else if (s_reg.nmi_pend) begin
            s_next.req  = 1'b1;
            s_next.kind = pic_pkg::PIC_KIND_NMI;
            s_next.idx  = 4'h0;
            s_next.typ  = `PIC_TYPE_NMI;
         end else if (found && s_reg.if_en) begin
            s_next.req  = 1'b1;
            s_next.kind = pic_pkg::PIC_KIND_MASK;
            s_next.idx  = best;
            s_next.typ  = sel_type;
         end
      end

      // Read data, one cycle after the strobe
      s_next.rdata = 32'h00000000;
      if (bus_in.rd) begin
         unique case (bus_in.addr)
            `PIC_ADDR_CTRL:  s_next.rdata = {29'h00000000, s_reg.sfn, s_reg.slave};
            `PIC_ADDR_MASK:  s_next.rdata = {22'h000000, s_reg.mask};
            `PIC_ADDR_PRIO:  s_next.rdata = {2'h0, s_reg.prio};
            `PIC_ADDR_ISR:   s_next.rdata = {22'h000000, s_reg.isr};
            `PIC_ADDR_PEND:  s_next.rdata = {19'h00000, s_reg.tmr_pend, s_reg.pend};
            `PIC_ADDR_BASE:  s_next.rdata = {27'h0000000, s_reg.base};
            `PIC_ADDR_EVST:  s_next.rdata = {28'h0000000, s_reg.evst};
            `PIC_ADDR_EVMSK: s_next.rdata = {28'h0000000, s_reg.evmsk};
            default:         s_next.rdata = 32'h00000000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_reg       <= '0;
         s_reg.mask  <= `PIC_MASK_RST;
         s_reg.prio  <= `PIC_PRIO_RST;
         s_reg.base  <= `PIC_BASE_RST;
         s_reg.kind  <= pic_pkg::PIC_KIND_EXC;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus_rdata_out        = s_reg.rdata;
   assign core_req_out         = s_reg.req;
   assign core_type_out        = s_reg.typ;
   assign core_vec_addr_out    = {s_reg.typ, 2'b00};
   assign in_service_flags_out = s_reg.isr;
   assign irq_out              = |(s_reg.evst & s_reg.evmsk);

endmodule

// ===== pkg/pic_defines.svh
/*
 * Offsets, field positions, reset values and vector codes of the
 * prioritized interrupt controller.
 * Assumes inclusion by its bare name from the package and the core.
 */
// How it works
// - Five pins, nonmaskable, seven internal sources accepted
// - Highest ranked pending request offered alone
// - Slave mode: external controller on pin 0
// - Higher priority request preempts lower service
// - Accept clears enable; re-enabled allows equal/higher
// - In-service bit blocks same source again
// - Special nested bit unblocks pins 0, 1
// - Timers share slot, EOI 08h, 0>1>2
// - Default priority levels as listed, reprogrammable
// - Fixed vector types for maskable sources
// - Watchdog type 11h, EOI 11h, level 7
// - Nonmaskable type 02h, trace just above, no EOI
// - Exceptions highest, fixed types 00h, 03h to 07h
// - Escape opcode traps through type 07h
// - Slave mode: timer, DMA types programmable
// - Slave mode: pins 1-4, watchdog, serial off
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define PIC_NSRC        10
`define PIC_NEXC        6
`define PIC_NEVT        4

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PIC_ADDR_CTRL   4'h0
`define PIC_ADDR_MASK   4'h1
`define PIC_ADDR_PRIO   4'h2
`define PIC_ADDR_ISR    4'h3
`define PIC_ADDR_PEND   4'h4
`define PIC_ADDR_EOI    4'h5
`define PIC_ADDR_BASE   4'h6
`define PIC_ADDR_EVST   4'h7
`define PIC_ADDR_EVMSK  4'h8

// ------------------------------------------------------------
// Control fields and reset values
// ------------------------------------------------------------
`define PIC_CTRL_SLAVE  0
`define PIC_CTRL_SFN0   1
`define PIC_CTRL_SFN1   2
`define PIC_MASK_RST    10'h3FF
`define PIC_PRIO_RST    30'h3FFAC688
`define PIC_BASE_RST    5'h01
`define PIC_LVL_NONE    4'h8

// ------------------------------------------------------------
// Vector types
// ------------------------------------------------------------
`define PIC_TYPE_TRACE  8'h01
`define PIC_TYPE_NMI    8'h02
`define PIC_TYPE_TMR0   8'h08
`define PIC_TYPE_TMR1   8'h12
`define PIC_TYPE_TMR2   8'h13
`define PIC_TYPE_DMA0   8'h0A
`define PIC_TYPE_DMA1   8'h0B
`define PIC_TYPE_PIN0   8'h0C
`define PIC_TYPE_PIN4   8'h10
`define PIC_TYPE_WDOG   8'h11
`define PIC_TYPE_SER    8'h14
`define PIC_EXC_TYPES   48'h070605040300

`endif

// ===== pkg/pic_pkg.sv
/*
 * Types of the prioritized interrupt controller.
 * Assumes the defines header sits beside it on the include path.
 */
`include "pic_defines.svh"

package pic_pkg;

   typedef enum logic [1:0] {
      PIC_KIND_EXC,
      PIC_KIND_TRACE,
      PIC_KIND_NMI,
      PIC_KIND_MASK
   } pic_kind_type;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pic_bus_type;

   typedef struct packed {
      logic [5:0]              sync1;
      logic [5:0]              sync2;
      logic [5:0]              prev;
      logic [7:0]              evec1;
      logic [7:0]              evec2;
      logic                    slave;
      logic [1:0]              sfn;
      logic [`PIC_NSRC-1:0]    mask;
      logic [3*`PIC_NSRC-1:0]  prio;
      logic [4:0]              base;
      logic [`PIC_NEVT-1:0]    evst;
      logic [`PIC_NEVT-1:0]    evmsk;
      logic [`PIC_NSRC-1:0]    pend;
      logic [2:0]              tmr_pend;
      logic [`PIC_NSRC-1:0]    isr;
      logic                    nmi_pend;
      logic                    trace_pend;
      logic [`PIC_NEXC-1:0]    exc_pend;
      logic                    if_en;
      logic                    req;
      logic [7:0]              typ;
      pic_kind_type            kind;
      logic [3:0]              idx;
      logic [31:0]             rdata;
   } pic_state_type;

endpackage

// ===== tb/pic_core_monitor.sv
/*
 * Port-level checks of the interrupt controller core, bound into pic_core.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module pic_core_monitor #(
   parameter int NSRC = 10
) (
   // Clock and reset
   input wire logic                 sys_clk_in,
   input wire logic                 rst_in,
   // Register port
   input wire pic_pkg::pic_bus_type bus_in,
   // Processor core
   input wire logic                 core_ack_in,
   input wire logic                 core_req_out,
   input wire logic [7:0]           core_type_out,
   input wire logic [9:0]           core_vec_addr_out,
   input wire logic [9:0]           in_service_flags_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   logic taken;
   assign taken = core_ack_in && core_req_out;

   chk_vec_addr: assert property (core_req_out |-> core_vec_addr_out == {core_type_out, 2'b00})
      else $error("vector address is not type times four");
   chk_ack_drop: assert property (taken |=> !core_req_out)
      else $error("offer still up after acknowledge");
   chk_type_known: assert property (core_req_out |-> core_type_out != 8'h09 && core_type_out <= 8'h14)
      else $error("offered type is reserved");
   chk_isr_cause: assert property ((|(in_service_flags_out & ~$past(in_service_flags_out))) |-> $past(taken))
      else $error("in-service bit set without acceptance");
   chk_isr_onehot: assert property ($onehot0(in_service_flags_out & ~$past(in_service_flags_out)))
      else $error("more than one source entered service");
   chk_exc_no_isr: assert property (taken && core_type_out < 8'h08 |=> $stable(in_service_flags_out))
      else $error("exception or nonmaskable changed in-service bits");
   chk_isr_clear: assert property (!$past(rst_in) && (|($past(in_service_flags_out) & ~in_service_flags_out))
      |-> $past(bus_in.wr) && $past(bus_in.addr) == 4'h5)
      else $error("in-service bit cleared without end-of-interrupt");
   chk_pin1_slot: assert property (taken && core_type_out == 8'h0D |=> in_service_flags_out[4])
      else $error("pin 1 acceptance did not mark its slot");
endmodule

bind pic_core pic_core_monitor #(.NSRC(NSRC)) u_mon (
   .sys_clk_in           (sys_clk_in),
   .rst_in               (rst_in),
   .bus_in               (bus_in),
   .core_ack_in          (core_ack_in),
   .core_req_out         (core_req_out),
   .core_type_out        (core_type_out),
   .core_vec_addr_out    (core_vec_addr_out),
   .in_service_flags_out (in_service_flags_out)
);

// ===== tb/pic_cpu_model.sv
/*
 * Processor core model: acknowledges a standing offer after a set delay.
 * Assumes the offer is a registered level on the same clock.
 */
`timescale 1ns/100ps

module pic_cpu_model (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   // Offer
   input  wire logic       core_req_in,
   input  wire logic [3:0] delay_in,
   output logic            core_ack_out
);
   logic [3:0] wait_reg;

   // One-cycle acknowledge, never twice for one offer
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !core_req_in || core_ack_out) begin
         wait_reg     <= 4'h0;
         core_ack_out <= 1'b0;
      end else if (wait_reg >= delay_in) begin
         core_ack_out <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench of the interrupt controller core.
 * Assumes the package is compiled first and the monitor is bound in.
 */
`timescale 1ns/100ps

module testbench;
   logic                 sys_clk_in;
   logic                 rst_in;
   pic_pkg::pic_bus_type bus;
   logic [31:0]          rdata;
   logic [21:0]          kick_vec;
   logic [7:0]           ext_vec;
   logic [3:0]           delay;
   logic                 ack;
   logic                 req;
   logic [7:0]           typ;
   logic [9:0]           vaddr;
   logic [9:0]           isr;
   logic                 irq;
   logic [31:0]          got;
   int                   fails;
   int                   n_tests;
   int                   cycles;
   localparam logic [47:0] EXC = 48'h070605040300;

   pic_core dut (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus), .bus_rdata_out(rdata),
      .ext_request_pin_0_in(kick_vec[0]), .ext_request_pin_1_in(kick_vec[1]),
      .ext_request_pin_2_in(kick_vec[2]), .ext_request_pin_3_in(kick_vec[3]),
      .ext_request_pin_4_in(kick_vec[4]), .nmi_pin_in(kick_vec[5]), .ext_vector_pin_in(ext_vec),
      .timer_req_in(kick_vec[8:6]), .dma_req_in(kick_vec[10:9]), .watchdog_req_in(kick_vec[11]),
      .serial_req_in(kick_vec[12]), .trace_req_in(kick_vec[13]), .core_set_if_in(kick_vec[14]),
      .exc_req_in(kick_vec[20:15]), .core_clr_if_in(kick_vec[21]), .core_ack_in(ack),
      .core_req_out(req), .core_type_out(typ), .core_vec_addr_out(vaddr),
      .in_service_flags_out(isr), .irq_out(irq)
   );

   pic_cpu_model u_cpu (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .core_req_in(req), .delay_in(delay), .core_ack_out(ack)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic test_done();
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_in);
      bus.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_in);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic kick(input logic [21:0] v);
      @(posedge sys_clk_in);
      kick_vec <= v;
      @(posedge sys_clk_in);
      kick_vec <= '0;
   endtask

   // Waits for the model's acknowledge, then checks what was taken
   task automatic take(input logic [7:0] exp);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (!(ack === 1'b1 && req === 1'b1) && n < 40);
      chk({24'h0, typ}, {24'h0, exp});
      chk({22'h0, vaddr}, {22'h0, exp, 2'b00});
      @(posedge sys_clk_in);
      // Let the accepting edge settle before anyone looks
      #1;
   endtask

   task automatic none(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge sys_clk_in);
         if (req !== 1'b0) seen = 1'b1;
      end
      chk({31'h0, seen}, 32'h0);
   endtask

   task automatic eoi(input logic [7:0] t);
      wr(4'h5, {24'h0, t});
   endtask

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // Whole run is about 300 cycles
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         test_done();
      end
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      fails = 0;
      n_tests = 0;
      cycles = 0;
      rst_in = 1'b1;
      bus = '0;
      kick_vec = '0;
      ext_vec = 8'h0F;
      delay = 4'h0;
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(4'h2, got);
      chk(got, 32'h3FFAC688);
      rd(4'h3, got);
      chk(got, 32'h0);
      rd(4'hF, got);
      chk(got, 32'h0);
      wr(4'h1, 32'h0);
      wr(4'h8, 32'h1);
      // Timers outrank DMA; shared slot blocks until end-of-interrupt
      kick(22'h000340);
      none(10);
      kick(22'h004000);
      take(8'h08);
      chk({31'h0, irq}, 32'h1);
      kick(22'h004000);
      none(10);
      eoi(8'h08);
      kick(22'h004000);
      take(8'h13);
      eoi(8'h08);
      kick(22'h004000);
      take(8'h0A);
      eoi(8'h0A);
      wr(4'h8, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(4'h8, 32'h1);
      wr(4'h7, 32'h1);
      chk({31'h0, irq}, 32'h0);
      // Higher level preempts a running handler
      kick(22'h000004);
      kick(22'h004000);
      take(8'h0E);
      kick(22'h004000);
      kick(22'h000400);
      take(8'h0B);
      eoi(8'h0B);
      eoi(8'h0E);
      // Same source blocked unless special nesting is on
      delay <= 4'h3;
      kick(22'h000001);
      kick(22'h004000);
      take(8'h0C);
      kick(22'h004000);
      kick(22'h000001);
      none(12);
      wr(4'h0, 32'h2);
      take(8'h0C);
      eoi(8'h0C);
      eoi(8'h0C);
      wr(4'h0, 32'h0);
      chk({22'h0, isr}, 32'h0);
      // Cleared enable and mask both hold a request back
      kick(22'h004000);
      kick(22'h200000);
      kick(22'h000002);
      none(12);
      wr(4'h1, 32'h010);
      kick(22'h004000);
      none(12);
      wr(4'h1, 32'h0);
      take(8'h0D);
      eoi(8'h0D);
      // Exceptions, trace and nonmaskable
      delay <= 4'h0;
      for (int i = 0; i < 6; i++) begin
         kick(22'h1 << (15 + i));
         take(EXC[8*i +: 8]);
      end
      delay <= 4'h8;
      kick(22'h000020);
      // Lets the nonmaskable offer come up before it is outranked
      repeat (6) @(posedge sys_clk_in);
      kick(22'h102000);
      take(8'h07);
      take(8'h01);
      take(8'h02);
      eoi(8'h33);
      rd(4'h7, got);
      chk({31'h0, got[3]}, 32'h1);
      // Slave mode: cascade master, programmable types, sources off
      delay <= 4'h1;
      wr(4'h6, 32'h02);
      wr(4'h0, 32'h1);
      kick(22'h001810);
      kick(22'h004000);
      none(16);
      kick(22'h000080);
      take(8'h11);
      eoi(8'h08);
      kick(22'h004000);
      kick(22'h000200);
      take(8'h13);
      eoi(8'h0A);
      kick(22'h004000);
      kick(22'h000001);
      take(8'h0F);
      // Back in master mode the held sources come through
      eoi(8'h0C);
      wr(4'h0, 32'h0);
      kick(22'h004000);
      take(8'h10);
      kick(22'h004000);
      take(8'h11);
      kick(22'h004000);
      take(8'h14);
      test_done();
   end
endmodule
